// [rbs_alu.sv]
// Rotate, byte reverse and hash transform execution datapath
`timescale 1ns/100ps
`default_nettype none
module rbs_alu
    import rbs_pkg::*;
#(
    parameter bit P_RV64 = 1'b1
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Issue from the pipeline
    input wire logic i_valid,
    input wire logic [31:0] i_instr,
    input wire logic [XLEN-1:0] i_rs1,
    input wire logic [XLEN-1:0] i_rs2,
    // Result to writeback
    output logic o_valid,
    output logic o_match,
    output logic o_reserved,
    output logic [XLEN-1:0] o_result
);

    // Decode one instruction word for the given configuration
    function automatic rbs_op_e decode_op(input logic [31:0] ins, input logic rv64);
        logic [6:0] opc;
        logic [2:0] f3;
        logic [6:0] f7;
        rbs_op_e op;
        opc = ins[6:0];
        f3 = ins[14:12];
        f7 = ins[31:25];
        op = OP_NONE;
        if (opc == OPC_IMM && f3 == F3_ROR) begin
            if (ins[31:20] == (rv64 ? REV_IMM_64 : REV_IMM_32)) begin
                op = OP_REV;
            end else if (ins[31:26] == F6_ROT_IMM) begin
                op = OP_RORI;
            end
        end else if (opc == OPC_IMM && f3 == F3_HASH && f7 == F7_HASH) begin
            case (ins[24:20])
                SEL_SIG0: op = OP_SIG0;
                SEL_SIG1: op = OP_SIG1;
                SEL_SUM0: op = OP_SUM0;
                SEL_SUM1: op = OP_SUM1;
                default: op = OP_NONE;
            endcase
        end else if (opc == OPC_REG && f7 == F7_ROT) begin
            if (f3 == F3_ROL) begin
                op = OP_ROL;
            end else if (f3 == F3_ROR) begin
                op = OP_ROR;
            end
        end else if (rv64 && opc == OPC_REG_W && f7 == F7_ROT) begin
            if (f3 == F3_ROL) begin
                op = OP_ROLW;
            end else if (f3 == F3_ROR) begin
                op = OP_RORW;
            end
        end else if (rv64 && opc == OPC_IMM_W && f7 == F7_ROT && f3 == F3_ROR) begin
            op = OP_RORIW;
        end
        return op;
    endfunction

    // Rotate the full register; left is a right rotate by the negated amount
    function automatic logic [XLEN-1:0] rot_full(input logic [XLEN-1:0] v,
                                                  input logic [5:0] s,
                                                  input logic right);
        logic [5:0] r;
        r = right ? s : (~s + 6'h01);
        if (P_RV64) begin
            return rbs_ror64(v, r);
        end
        return {32'h0000_0000, rbs_ror32(v[WORD-1:0], r[4:0])};
    endfunction

    // Sign extend a word to the register width
    function automatic logic [XLEN-1:0] sext_word(input logic [WORD-1:0] w);
        return {{(XLEN-WORD){w[WORD-1]}}, w};
    endfunction

    rbs_op_e op_d;
    logic reserved_d;
    logic [5:0] amt_reg;
    logic [5:0] amt_imm;
    logic [4:0] amt_word_reg;
    logic [4:0] amt_word_imm;
    logic [XLEN-1:0] rev64;
    logic [WORD-1:0] rev32;
    logic [XLEN-1:0] hash_ext;
    logic [XLEN-1:0] result_d;
    logic valid_q;
    logic match_q;
    logic reserved_q;
    logic [XLEN-1:0] result_q;

    rbs_hash_if hash_bus ();

    // Transform network lives in its own unit
    rbs_hash_unit u_hash (
        .bus (hash_bus.unit)
    );

    // Decode and rotate amounts; upper amount bit only counts in 64-bit mode
    assign op_d = decode_op(i_instr, P_RV64);
    assign amt_reg = P_RV64 ? i_rs2[5:0] : {1'b0, i_rs2[4:0]};
    assign amt_imm = P_RV64 ? i_instr[25:20] : {1'b0, i_instr[24:20]};
    assign amt_word_reg = i_rs2[4:0];
    assign amt_word_imm = i_instr[24:20];
    // A 32-bit immediate rotate with bit 5 set is reserved, never executed
    assign reserved_d = !P_RV64 && op_d == OP_RORI && i_instr[25];

    // Byte reversal for both widths, wired so every width is always present
    genvar k;
    for (k = 0; k < BYTES; k++) begin : g_rev64
        assign rev64[8*(BYTES-1-k) +: 8] = i_rs1[8*k +: 8];
    end
    for (k = 0; k < WBYTES; k++) begin : g_rev32
        assign rev32[8*(WBYTES-1-k) +: 8] = i_rs1[8*k +: 8];
    end

    // Hash word: low word of the source, which is the whole register in 32-bit mode
    assign hash_bus.word = i_rs1[WORD-1:0];
    assign hash_ext = P_RV64 ? sext_word(hash_bus.digest)
                             : {32'h0000_0000, hash_bus.digest};

    // Selector mirrors bits 21..20 of the hash encodings
    always_comb begin
        case (op_d)
            OP_SIG0: hash_bus.sel = HASH_SIG0;
            OP_SIG1: hash_bus.sel = HASH_SIG1;
            OP_SUM1: hash_bus.sel = HASH_SUM1;
            default: hash_bus.sel = HASH_SUM0;
        endcase
    end

    // Result select; a zero amount falls out of the rotate itself
    always_comb begin
        case (op_d)
            OP_REV: result_d = P_RV64 ? rev64 : {32'h0000_0000, rev32};
            OP_ROL: result_d = rot_full(i_rs1, amt_reg, 1'b0);
            OP_ROR: result_d = rot_full(i_rs1, amt_reg, 1'b1);
            OP_RORI: result_d = reserved_d ? RESULT_RST : rot_full(i_rs1, amt_imm, 1'b1);
            OP_ROLW: begin
                result_d = sext_word(rbs_ror32(i_rs1[WORD-1:0], ~amt_word_reg + 5'h01));
            end
            OP_RORW: begin
                result_d = sext_word(rbs_ror32(i_rs1[WORD-1:0], amt_word_reg));
            end
            OP_RORIW: begin
                result_d = sext_word(rbs_ror32(i_rs1[WORD-1:0], amt_word_imm));
            end
            OP_SIG0, OP_SIG1, OP_SUM0, OP_SUM1: result_d = hash_ext;
            default: result_d = RESULT_RST;
        endcase
    end

    // Single register stage: every operation answers after the same cycle count
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= i_valid;
        end
    end

    // Result and flags are only updated on issue, holding otherwise
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            match_q <= 1'b0;
            reserved_q <= 1'b0;
            result_q <= RESULT_RST;
        end else if (i_valid) begin
            match_q <= (op_d != OP_NONE) && !reserved_d;
            reserved_q <= reserved_d;
            result_q <= result_d;
        end
    end

    assign o_valid = valid_q;
    assign o_match = match_q;
    assign o_reserved = reserved_q;
    assign o_result = result_q;

    // Checks, all on the one clock and disabled in reset
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_issue(rbs_op_e op);
        i_valid && op_d == op;
    endsequence

    sequence s_hash_issue;
        i_valid && (op_d == OP_SIG0 || op_d == OP_SIG1 || op_d == OP_SUM0 || op_d == OP_SUM1);
    endsequence

    fixed_latency_a: assert property (s_hash_issue |-> ##1 o_valid && o_match)
        else $error("hash result not returned after one cycle");
    rev_bytes_a: assert property (s_issue(OP_REV) |=>
        o_result[7:0] == $past(i_rs1[(P_RV64 ? XLEN : WORD)-1 -: 8]))
        else $error("byte reverse low byte wrong");
    rev_other_cfg_a: assert property (i_valid && i_instr[6:0] == OPC_IMM
        && i_instr[14:12] == F3_ROR
        && i_instr[31:20] == (P_RV64 ? REV_IMM_32 : REV_IMM_64) |=> !o_match)
        else $error("byte reverse accepted under the other width encoding");
    rol_zero_a: assert property ((s_issue(OP_ROL) and (amt_reg == 6'h00))
        |=> o_result == (P_RV64 ? $past(i_rs1) : {32'h0000_0000, $past(i_rs1[WORD-1:0])}))
        else $error("zero rotate left changed the source");
    ror_inverse_a: assert property (s_issue(OP_ROR) |=>
        rot_full(o_result, $past(amt_reg), 1'b0) == $past(rot_full(i_rs1, 6'h00, 1'b1)))
        else $error("rotate right does not invert by rotate left");
    word_sext_a: assert property ((s_issue(OP_ROLW) or s_issue(OP_RORW)
        or s_issue(OP_RORIW)) |=> o_result[XLEN-1:WORD] == {(XLEN-WORD){o_result[WORD-1]}})
        else $error("word rotate not sign extended");
    rori_reserved_a: assert property (i_valid && !P_RV64 && i_instr[6:0] == OPC_IMM
        && i_instr[14:12] == F3_ROR && i_instr[31:26] == F6_ROT_IMM && i_instr[25]
        |=> o_reserved && !o_match)
        else $error("reserved immediate rotate executed");
    hash_sext_a: assert property ((s_hash_issue and (P_RV64 == 1'b1)) |=>
        o_result[XLEN-1:WORD] == {(XLEN-WORD){o_result[WORD-1]}})
        else $error("hash result not sign extended");
    sig0_decode_a: assert property (i_valid && i_instr[31:25] == F7_HASH
        && i_instr[24:20] == SEL_SIG0 && i_instr[14:12] == F3_HASH && i_instr[6:0] == OPC_IMM
        |-> op_d == OP_SIG0 ##1 o_match)
        else $error("sigma0 encoding not decoded");
    sig1_decode_a: assert property (i_valid && i_instr[31:25] == F7_HASH
        && i_instr[24:20] == SEL_SIG1 && i_instr[14:12] == F3_HASH && i_instr[6:0] == OPC_IMM
        |-> op_d == OP_SIG1 ##1 o_match)
        else $error("sigma1 encoding not decoded");
    idle_hold_a: assert property (!i_valid |=> !o_valid && $stable(o_result))
        else $error("result moved without an issue");

endmodule
`default_nettype wire

// [rbs_alu_test.sv]
// Self-checking bench for both widths of the rotate, byte reverse and hash datapath
`timescale 1ns/100ps
`default_nettype none
module rbs_alu_test;
    import rbs_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic v;
    logic [31:0] ins;
    logic [63:0] a, b, w_res, n_res;
    logic w_valid, w_match, w_rsv, n_valid, n_match, n_rsv;
    int fails = 0;
    int num_checks = 0;
    int amts[5] = '{0, 1, 31, 32, 63};

    rbs_pipe_model i_rbs_pipe_model (.i_ref_clk(i_ref_clk), .o_valid(v), .o_instr(ins),
        .o_rs1(a), .o_rs2(b));
    // Wide and narrow configurations see the same issue stream
    rbs_alu #(.P_RV64(1'b1)) i_rbs_alu (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_valid(v),
        .i_instr(ins), .i_rs1(a), .i_rs2(b), .o_valid(w_valid), .o_match(w_match),
        .o_reserved(w_rsv), .o_result(w_res));
    rbs_alu #(.P_RV64(1'b0)) i_rbs_alu_narrow (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_valid(v), .i_instr(ins), .i_rs1(a), .i_rs2(b), .o_valid(n_valid),
        .o_match(n_match), .o_reserved(n_rsv), .o_result(n_res));

    // 200 MHz core clock
    always #2.5 i_ref_clk = ~i_ref_clk;

    // Reference arithmetic, kept apart from the design's own helpers
    function automatic logic [63:0] rr64(input logic [63:0] x, input int s);
        return (x >> s) | (x << (64 - s));
    endfunction
    function automatic logic [31:0] rr32(input logic [31:0] x, input int s);
        return (x >> s) | (x << (32 - s));
    endfunction
    function automatic logic [63:0] sx(input logic [31:0] x);
        return {{32{x[31]}}, x};
    endfunction
    function automatic logic [31:0] hf(input int k, input logic [31:0] x);
        case (k)
            0: return rr32(x, 2) ^ rr32(x, 13) ^ rr32(x, 22);
            1: return rr32(x, 6) ^ rr32(x, 11) ^ rr32(x, 25);
            2: return rr32(x, 7) ^ rr32(x, 18) ^ (x >> 3);
            default: return rr32(x, 17) ^ rr32(x, 19) ^ (x >> 10);
        endcase
    endfunction
    function automatic logic [31:0] enc(input logic [11:0] hi, input logic [2:0] f3,
        input logic [6:0] opc);
        return {hi, 5'h0A, f3, 5'h05, opc};
    endfunction

    task automatic results();
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // One issue; both widths judged one cycle later, then the wide result must hold
    task automatic op(input logic [31:0] i, input logic [63:0] x, input logic [63:0] y,
        input logic [63:0] ew, input logic mw, input logic [63:0] en, input logic mn,
        input logic rn);
        i_rbs_pipe_model.issue(i, x, y);
        chk_flag(w_valid, 1'b1);
        chk_flag(n_valid, 1'b1);
        chk_flag(w_match, mw);
        chk_val(w_res, ew);
        chk_flag(w_rsv, 1'b0);
        chk_flag(n_match, mn);
        chk_val(n_res, en);
        chk_flag(n_rsv, rn);
        @(negedge i_ref_clk);
        chk_flag(w_valid, 1'b0);
        chk_val(w_res, ew);
    endtask

    task automatic t_rev();
        logic [63:0] x;
        x = 64'h0123_4567_89AB_CDEF;
        op(enc(REV_IMM_64, F3_ROR, OPC_IMM), x, 64'h0, 64'hEFCD_AB89_6745_2301, 1'b1,
            64'h0, 1'b0, 1'b0);
        op(enc(REV_IMM_32, F3_ROR, OPC_IMM), x, 64'h0, 64'h0, 1'b0,
            64'h0000_0000_EFCD_AB89, 1'b1, 1'b0);
    endtask

    // Amount bits above the register width are set to prove they are ignored
    task automatic t_rot();
        logic [63:0] x;
        logic [63:0] y;
        x = 64'h8123_4567_89AB_CDEF;
        foreach (amts[j]) begin
            y = 64'hFFFF_FFFF_FFFF_FFC0 | 64'(amts[j]);
            op(enc({F7_ROT, 5'h0B}, F3_ROL, OPC_REG), x, y, rr64(x, (64 - amts[j]) % 64),
                1'b1, {32'h0, rr32(x[31:0], (32 - amts[j] % 32) % 32)}, 1'b1,
                1'b0);
            op(enc({F7_ROT, 5'h0B}, F3_ROR, OPC_REG), x, y, rr64(x, amts[j]), 1'b1,
                {32'h0, rr32(x[31:0], amts[j] % 32)}, 1'b1, 1'b0);
        end
    endtask

    // Word forms exist only in the wide configuration
    task automatic t_wrot();
        logic [63:0] x;
        int s;
        x = 64'h1234_0000_8000_0001;
        foreach (amts[j]) begin
            s = amts[j] % 32;
            op(enc({F7_ROT, 5'h0B}, F3_ROL, OPC_REG_W), x, 64'hFFFF_FFE0 | 64'(s),
                sx(rr32(x[31:0], (32 - s) % 32)), 1'b1, 64'h0, 1'b0, 1'b0);
            op(enc({F7_ROT, 5'h0B}, F3_ROR, OPC_REG_W), x, 64'hFFFF_FFE0 | 64'(s),
                sx(rr32(x[31:0], s)), 1'b1, 64'h0, 1'b0, 1'b0);
            op(enc({F7_ROT, 5'(s)}, F3_ROR, OPC_IMM_W), x, 64'h0, sx(rr32(x[31:0], s)),
                1'b1, 64'h0, 1'b0, 1'b0);
        end
    endtask

    task automatic t_rori();
        logic [63:0] x;
        logic nr;
        x = 64'hF0E1_D2C3_B4A5_9687;
        foreach (amts[j]) begin
            nr = (amts[j] >= 32);
            op(enc({F6_ROT_IMM, 6'(amts[j])}, F3_ROR, OPC_IMM), x, 64'h0, rr64(x, amts[j]),
                1'b1, nr ? 64'h0 : {32'h0, rr32(x[31:0], amts[j])}, !nr, nr);
        end
    endtask

    // Upper source bits are non-zero so a leak into the word input shows
    task automatic t_hash();
        logic [63:0] xs[2];
        xs = '{64'hA5A5_0000_6A09_E667, 64'h1234_5678_9ABC_DEF0};
        for (int k = 0; k < 4; k++) begin
            foreach (xs[j]) begin
                op(enc({F7_HASH, 5'(k)}, F3_HASH, OPC_IMM), xs[j], 64'h0,
                    sx(hf(k, xs[j][31:0])), 1'b1, {32'h0, hf(k, xs[j][31:0])}, 1'b1,
                    1'b0);
            end
        end
        op(enc({F7_HASH, 5'h04}, F3_HASH, OPC_IMM), xs[0], 64'h0, 64'h0, 1'b0, 64'h0, 1'b0,
            1'b0);
    endtask

    // Watchdog well beyond the roughly 130 cycles the sequence needs
    initial begin
        #20000;
        fails++;
        results();
    end

    // Reset, then every scenario in turn
    initial begin
        repeat (4) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rst = 1'b0;
        chk_flag(w_valid, 1'b0);
        chk_val(w_res, 64'h0);
        chk_val(n_res, 64'h0);
        t_rev();
        t_rot();
        t_wrot();
        t_rori();
        t_hash();
        results();
    end
endmodule
`default_nettype wire

// [rbs_hash_if.sv]
// Carrier between the datapath and its hash transform unit
`timescale 1ns/100ps
`default_nettype none
interface rbs_hash_if;
    import rbs_pkg::*;

    logic [WORD-1:0] word;
    rbs_hash_e sel;
    logic [WORD-1:0] digest;

    // Datapath side drives the word and selector
    modport ctl (output word, output sel, input digest);
    // Unit side returns the transformed word
    modport unit (input word, input sel, output digest);
endinterface
`default_nettype wire

// [rbs_hash_unit.sv]
// Constant-time 32-bit message schedule and compression transforms
`timescale 1ns/100ps
`default_nettype none
module rbs_hash_unit
    import rbs_pkg::*;
(
    // Transform request and answer
    rbs_hash_if.unit bus
);

    // Pure XOR of rotates and shifts: no data dependent path length
    // One network serves both the 224 and 256 digest sizes
    always_comb begin
        case (bus.sel)
            HASH_SIG0: begin
                bus.digest = rbs_ror32(bus.word, SIG0_R1) ^ rbs_ror32(bus.word, SIG0_R2)
                    ^ (bus.word >> SIG0_SH);
            end
            HASH_SIG1: begin
                bus.digest = rbs_ror32(bus.word, SIG1_R1) ^ rbs_ror32(bus.word, SIG1_R2)
                    ^ (bus.word >> SIG1_SH);
            end
            HASH_SUM0: begin
                bus.digest = rbs_ror32(bus.word, SUM0_R1) ^ rbs_ror32(bus.word, SUM0_R2)
                    ^ rbs_ror32(bus.word, SUM0_R3);
            end
            HASH_SUM1: begin
                bus.digest = rbs_ror32(bus.word, SUM1_R1) ^ rbs_ror32(bus.word, SUM1_R2)
                    ^ rbs_ror32(bus.word, SUM1_R3);
            end
            default: begin
                bus.digest = '0;
            end
        endcase
    end

endmodule
`default_nettype wire

// [rbs_pipe_model.sv]
// Issue stage model that presents one instruction and its operands to the datapath
`timescale 1ns/100ps
`default_nettype none
module rbs_pipe_model
    import rbs_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Issue towards the datapath
    output logic o_valid,
    output logic [31:0] o_instr,
    output logic [XLEN-1:0] o_rs1,
    output logic [XLEN-1:0] o_rs2
);
    // Idle after power up: nothing issued
    initial begin
        o_valid = 1'b0;
        o_instr = 32'h0000_0000;
        o_rs1 = 64'h0;
        o_rs2 = 64'h0;
    end

    // One issue held across exactly one rising edge, then withdrawn
    task automatic issue(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
        @(negedge i_ref_clk);
        o_valid = 1'b1;
        o_instr = ins;
        o_rs1 = a;
        o_rs2 = b;
        @(negedge i_ref_clk);
        // Stale lines are inverted so a late sample can never pass for the live value
        o_valid = 1'b0;
        o_instr = ~ins;
        o_rs1 = ~a;
        o_rs2 = ~b;
    endtask
endmodule
`default_nettype wire

// [rbs_pkg.sv]
// Shared constants, types and rotate helpers for the rotate, byte-swap and hash datapath
package rbs_pkg;

    // Datapath widths
    localparam int XLEN = 64;
    localparam int WORD = 32;
    localparam int BYTES = XLEN / 8;
    localparam int WBYTES = WORD / 8;

    // Fixed latency from issue to result, identical for every operation
    localparam int LAT_CYCLES = 1;

    // Major opcodes
    localparam logic [6:0] OPC_IMM = 7'h13;
    localparam logic [6:0] OPC_REG = 7'h33;
    localparam logic [6:0] OPC_IMM_W = 7'h1B;
    localparam logic [6:0] OPC_REG_W = 7'h3B;

    // Function fields of the rotate group
    localparam logic [6:0] F7_ROT = 7'h30;
    localparam logic [5:0] F6_ROT_IMM = 6'h18;
    localparam logic [2:0] F3_ROL = 3'h1;
    localparam logic [2:0] F3_ROR = 3'h5;

    // Byte reverse immediate field, one per configuration
    localparam logic [11:0] REV_IMM_32 = 12'h698;
    localparam logic [11:0] REV_IMM_64 = 12'h6B8;

    // Hash group fixed fields and selectors in bits 24..20
    localparam logic [6:0] F7_HASH = 7'h08;
    localparam logic [2:0] F3_HASH = 3'h1;
    localparam logic [4:0] SEL_SUM0 = 5'h00;
    localparam logic [4:0] SEL_SUM1 = 5'h01;
    localparam logic [4:0] SEL_SIG0 = 5'h02;
    localparam logic [4:0] SEL_SIG1 = 5'h03;

    // Rotate and shift distances of the four transforms
    localparam logic [4:0] SIG0_R1 = 5'h07;
    localparam logic [4:0] SIG0_R2 = 5'h12;
    localparam int SIG0_SH = 3;
    localparam logic [4:0] SIG1_R1 = 5'h11;
    localparam logic [4:0] SIG1_R2 = 5'h13;
    localparam int SIG1_SH = 10;
    localparam logic [4:0] SUM0_R1 = 5'h02;
    localparam logic [4:0] SUM0_R2 = 5'h0D;
    localparam logic [4:0] SUM0_R3 = 5'h16;
    localparam logic [4:0] SUM1_R1 = 5'h06;
    localparam logic [4:0] SUM1_R2 = 5'h0B;
    localparam logic [4:0] SUM1_R3 = 5'h19;

    // Values after reset
    localparam logic [XLEN-1:0] RESULT_RST = 64'h0000_0000_0000_0000;

    // Decoded operation
    typedef enum logic [3:0] {
        OP_NONE, OP_REV, OP_ROL, OP_ROLW, OP_ROR, OP_RORI, OP_RORIW, OP_RORW,
        OP_SIG0, OP_SIG1, OP_SUM0, OP_SUM1
    } rbs_op_e;

    // Transform selector carried to the hash unit
    typedef enum logic [1:0] {HASH_SUM0, HASH_SUM1, HASH_SIG0, HASH_SIG1} rbs_hash_e;

    // Rotate right of a full 64-bit value
    function automatic logic [63:0] rbs_ror64(input logic [63:0] v, input logic [5:0] s);
        logic [127:0] d;
        d = {v, v} >> s;
        return d[63:0];
    endfunction

    // Rotate right of a 32-bit word
    function automatic logic [31:0] rbs_ror32(input logic [31:0] v, input logic [4:0] s);
        logic [63:0] d;
        d = {v, v} >> s;
        return d[31:0];
    endfunction

endpackage
